/* ais_defines.svh */
/*
  Register indices, field positions and reset values of the converter
  input and reference select block. Assumes inclusion by bare name.
*/
// Overview of operation
// R1 - Reference field picks external, supply or internal
// R2 - Reference frozen after each start until enable cleared
// R3 - Software avoids internal reference with external applied
// R4 - Left-adjust bit aligns result left, else right
// R5 - Alignment change shows in data at once
// R6 - Low select writes wait for conversion end
// R7 - High select bit buffered until low write
// R8 - High select change waits for conversion end
// R9 - Codes 0-7 single-ended, from 8 differential
// R10 - Gains 10x/200x/1x, bandgap, ground, reserved codes
// R11 - Enable requests supply; supply-good bit reports it
// R12 - Enable turns reference on; reference-good reports it
// R13 - Channel-change write forces analog block reset
// R14 - Channel-change reads one until reset entered
// R15 - Start bit reads busy; writing zero ignored
// R16 - Done flag set at completion, write-one clears
// R17 - Enable off stops converter, aborts conversion
// R18 - Status bits read-only; registers reset to zero
`ifndef AIS_DEFINES_SVH
`define AIS_DEFINES_SVH
`define AIS_ADDR_W 12
`define AIS_IDX_DATA 10'h078
`define AIS_IDX_CSRA 10'h07A
`define AIS_IDX_CSRB 10'h07B
`define AIS_IDX_MUX 10'h07C
`define AIS_IDX_STAT 10'h080
`define AIS_IDX_MASK 10'h081
`define AIS_RST_BYTE 8'h00
`define AIS_MUX_LADJ 5
`define AIS_CSRB_AVDD 7
`define AIS_CSRB_CME 6
`define AIS_CSRB_REFERENCE_GOOD 5
`define AIS_CSRB_ANALOG_CHANNEL_CHANGE 4
`define AIS_CSRB_CHH 3
`define AIS_CSRA_EN 7
`define AIS_CSRA_START 6
`define AIS_CSRA_DONE 4
`define AIS_ST_DONE 0
`define AIS_ST_CHG 1
`define AIS_RESP_OK 2'h0
`define AIS_RESP_ERR 2'h2
`define AIS_CODE_DIFF 6'h08
`define AIS_CODE_G1 6'h10
`define AIS_CODE_BG 6'h1E
`define AIS_CODE_GND 6'h1F
`endif

/* ais_pkg.sv */
/*
  Types of the converter input and reference select block.
  Assumes the constants header is compiled alongside.
*/
package ais_pkg;
  typedef enum logic [1:0] {
    REF_EXT = 2'h0, REF_AVDD = 2'h1, REF_1V5 = 2'h2, REF_1V6 = 2'h3
  } ais_ref_t;
  typedef enum logic [1:0] {
    GAIN_NONE = 2'h0, GAIN_1 = 2'h1, GAIN_10 = 2'h2, GAIN_200 = 2'h3
  } ais_gain_t;
  typedef enum logic [2:0] {
    SRC_SE = 3'h0, SRC_DIFF = 3'h1, SRC_BG = 3'h2, SRC_GND = 3'h3, SRC_RSVD = 3'h4
  } ais_src_t;
  // Gray path: off, idle, busy
  typedef enum logic [1:0] {
    CV_OFF = 2'h0, CV_IDLE = 2'h1, CV_BUSY = 2'h3
  } ais_cv_t;
  typedef struct packed {
    logic        awready, wready, bvalid, aw_have, w_have, wen;
    logic [1:0]  bresp, rresp;
    logic [9:0]  awidx;
    logic [7:0]  wdata, mux;
    logic        arready, rvalid;
    logic [31:0] rdata;
    logic        chh_buf, cme, analog_channel_change, en, started, pend;
    logic [2:0]  trig;
    ais_cv_t     cst;
    ais_ref_t    ref_eff;
    logic [5:0]  sel_eff, sel_pend;
    ais_gain_t   gain;
    ais_src_t    src;
    logic [15:0] result;
    logic [1:0]  stat, mask, s_avdd, s_ref, s_rst;
    logic        irq, conv_start, ana_rst;
  } ais_state_t;
endpackage

/* ais_ctrl.sv */
/*
  Converter control: reference select, alignment, channel select with
  buffered high bit, supply and reference status, channel-change reset,
  AXI4-Lite register slave and interrupt. Assumes a sequencer on the
  same clock that reports conversion end, and async analog status pins.
*/
`timescale 1ns/1ps
`include "ais_defines.svh"
module ais_ctrl #(
  parameter int RES_W = 10                    // Conversion result width
) (
  input  wire logic                   clk_i,             // 40 MHz clock
  input  wire logic                   rst_i,             // Sync reset, high
  input  wire logic [`AIS_ADDR_W-1:0] s_axi_awaddr,      // Write address
  input  wire logic                   s_axi_awvalid,     // Write addr valid
  output logic                        s_axi_awready,     // Write addr ready
  input  wire logic [31:0]            s_axi_wdata,       // Write data
  input  wire logic [3:0]             s_axi_wstrb,       // Byte enables
  input  wire logic                   s_axi_wvalid,      // Write data valid
  output logic                        s_axi_wready,      // Write data ready
  output logic [1:0]                  s_axi_bresp,       // Write response
  output logic                        s_axi_bvalid,      // Response valid
  input  wire logic                   s_axi_bready,      // Response ready
  input  wire logic [`AIS_ADDR_W-1:0] s_axi_araddr,      // Read address
  input  wire logic                   s_axi_arvalid,     // Read addr valid
  output logic                        s_axi_arready,     // Read addr ready
  output logic [31:0]                 s_axi_rdata,       // Read data
  output logic [1:0]                  s_axi_rresp,       // Read response
  output logic                        s_axi_rvalid,      // Read valid
  input  wire logic                   s_axi_rready,      // Read ready
  input  wire logic                   conv_done_i,       // Sequencer end pulse
  input  wire logic [RES_W-1:0]       result_i,          // Result at end
  input  wire logic                   avdd_ok_i,         // Async supply good
  input  wire logic                   ref_ok_i,          // Async ref good
  input  wire logic                   rst_phase_ok_i,    // Async reset allowed
  output logic                        conv_start_o,      // Start pulse
  output logic                        conv_enable_o,     // Converter on
  output logic                        avdd_req_o,        // Supply request
  output logic                        ref_en_o,          // Reference enable
  output ais_pkg::ais_ref_t           ref_sel_o,         // Applied reference
  output logic [5:0]                  chan_sel_o,        // Applied channel
  output ais_pkg::ais_gain_t          gain_o,            // Amplifier gain
  output ais_pkg::ais_src_t           src_o,             // Input class
  output logic                        analog_reset_o,    // Reset phase pulse
  output logic                        irq_o              // Level interrupt
);

  if (RES_W < 1 || RES_W > 16) begin : g_bad_width
    $error("RES_W must be 1 to 16");
  end

  ais_pkg::ais_state_t st, nx;
  logic                wr_go, wr_csrb, wr_mux, wr_csra, wr_st, rd_go;
  logic [5:0]          new_sel;
  logic [15:0]         data_word;

  // R9 code decode
  // R10 gain and special codes
  function automatic ais_pkg::ais_gain_t gain_of(input logic [5:0] c);
    if (c >= `AIS_CODE_DIFF && c < `AIS_CODE_G1) begin
      return c[1] ? ais_pkg::GAIN_200 : ais_pkg::GAIN_10;
    end else if (c >= `AIS_CODE_G1 && c < `AIS_CODE_BG) begin
      return ais_pkg::GAIN_1;
    end
    return ais_pkg::GAIN_NONE;
  endfunction

  function automatic ais_pkg::ais_src_t src_of(input logic [5:0] c);
    if (c < `AIS_CODE_DIFF) begin
      return ais_pkg::SRC_SE;
    end else if (c < `AIS_CODE_BG) begin
      return ais_pkg::SRC_DIFF;
    end else if (c == `AIS_CODE_BG) begin
      return ais_pkg::SRC_BG;
    end else if (c == `AIS_CODE_GND) begin
      return ais_pkg::SRC_GND;
    end
    return ais_pkg::SRC_RSVD;
  endfunction

  // R4 alignment
  // R5 computed at read time, so a flip shows at once
  always_comb begin
    data_word = st.mux[`AIS_MUX_LADJ] ? (st.result << (16 - RES_W)) : st.result;
  end

  // Write strobes, taken once both halves are held
  always_comb begin
    wr_go   = st.aw_have && st.w_have && !st.bvalid;
    wr_csrb = wr_go && st.wen && st.awidx == `AIS_IDX_CSRB;
    wr_mux  = wr_go && st.wen && st.awidx == `AIS_IDX_MUX;
    wr_csra = wr_go && st.wen && st.awidx == `AIS_IDX_CSRA;
    wr_st   = wr_go && st.wen && st.awidx == `AIS_IDX_STAT;
    rd_go   = s_axi_arvalid && st.arready;
    new_sel = {st.chh_buf, st.wdata[4:0]};
  end

  always_comb begin
    nx = st;
    nx.conv_start = 1'b0;
    nx.ana_rst    = 1'b0;
    // Status pins: second stage only is read
    nx.s_avdd = {st.s_avdd[0], avdd_ok_i};
    nx.s_ref  = {st.s_ref[0], ref_ok_i};
    nx.s_rst  = {st.s_rst[0], rst_phase_ok_i};

    // Write address and data accepted in either order
    if (s_axi_awvalid && st.awready) begin
      nx.aw_have = 1'b1;
      nx.awidx   = s_axi_awaddr[`AIS_ADDR_W-1:2];
    end
    if (s_axi_wvalid && st.wready) begin
      nx.w_have = 1'b1;
      nx.wdata  = s_axi_wdata[7:0];
      nx.wen    = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end
    if (wr_go) begin
      nx.aw_have = 1'b0;
      nx.w_have  = 1'b0;
      nx.bvalid  = 1'b1;
      if (st.awidx == `AIS_IDX_CSRA || st.awidx == `AIS_IDX_CSRB
          || st.awidx == `AIS_IDX_MUX || st.awidx == `AIS_IDX_STAT
          || st.awidx == `AIS_IDX_MASK || st.awidx == `AIS_IDX_DATA) begin
        nx.bresp = `AIS_RESP_OK;
      end else begin
        nx.bresp = `AIS_RESP_ERR;
      end
    end
    nx.awready = !nx.aw_have && !nx.bvalid;
    nx.wready  = !nx.w_have && !nx.bvalid;

    // Read answer one cycle after the address is taken
    if (st.rvalid && s_axi_rready) begin
      nx.rvalid  = 1'b0;
      nx.arready = 1'b1;
    end else if (!st.rvalid) begin
      nx.arready = 1'b1;
    end
    if (rd_go) begin
      nx.rvalid  = 1'b1;
      nx.arready = 1'b0;
      nx.rresp   = `AIS_RESP_OK;
      nx.rdata   = '0;
      if (s_axi_araddr[`AIS_ADDR_W-1:2] == `AIS_IDX_MUX) begin
        nx.rdata[7:0] = st.mux;
      end else if (s_axi_araddr[`AIS_ADDR_W-1:2] == `AIS_IDX_CSRB) begin
        // R11 supply good
        // R12 reference good
        nx.rdata[7:0] = {st.s_avdd[1], st.cme, st.s_ref[1], st.analog_channel_change, st.chh_buf, st.trig};
      end else if (s_axi_araddr[`AIS_ADDR_W-1:2] == `AIS_IDX_CSRA) begin
        // R15 start reads busy
        nx.rdata[`AIS_CSRA_EN]    = st.en;
        nx.rdata[`AIS_CSRA_START] = st.cst == ais_pkg::CV_BUSY;
        nx.rdata[`AIS_CSRA_DONE]  = st.stat[`AIS_ST_DONE];
      end else if (s_axi_araddr[`AIS_ADDR_W-1:2] == `AIS_IDX_DATA) begin
        nx.rdata[15:0] = data_word;
      end else if (s_axi_araddr[`AIS_ADDR_W-1:2] == `AIS_IDX_STAT) begin
        nx.rdata[1:0] = st.stat;
      end else if (s_axi_araddr[`AIS_ADDR_W-1:2] == `AIS_IDX_MASK) begin
        nx.rdata[1:0] = st.mask;
      end else begin
        nx.rresp = `AIS_RESP_ERR;
      end
    end

    // R18 only writable fields stored
    if (wr_csrb) begin
      nx.cme     = st.wdata[`AIS_CSRB_CME];
      nx.chh_buf = st.wdata[`AIS_CSRB_CHH];
      nx.trig    = st.wdata[2:0];
    end
    if (wr_go && st.wen && st.awidx == `AIS_IDX_MASK) begin
      nx.mask = st.wdata[1:0];
    end

    // R7 high bit joins only on low write
    // R6 deferred while busy
    if (wr_mux) begin
      nx.mux = st.wdata;
      if (st.cst == ais_pkg::CV_BUSY) begin
        nx.sel_pend = new_sel;
        nx.pend     = 1'b1;
      end else begin
        nx.sel_eff = new_sel;
        nx.pend    = 1'b0;
      end
    end

    // Done flag write-one-clear, before any set below
    if (wr_st) begin
      nx.stat = st.stat & ~st.wdata[1:0];
    end
    if (wr_csra && st.wdata[`AIS_CSRA_DONE]) begin
      nx.stat[`AIS_ST_DONE] = 1'b0;
    end

    // Conversion state
    case (st.cst)
      ais_pkg::CV_OFF: begin
        if (wr_csra && st.wdata[`AIS_CSRA_EN]) begin
          nx.cst = ais_pkg::CV_IDLE;
          // R15 start with enable in one write
          if (st.wdata[`AIS_CSRA_START]) begin
            nx.cst        = ais_pkg::CV_BUSY;
            nx.conv_start = 1'b1;
            nx.started    = 1'b1;
          end
        end
      end
      ais_pkg::CV_IDLE: begin
        if (wr_csra && st.wdata[`AIS_CSRA_START]) begin
          nx.cst        = ais_pkg::CV_BUSY;
          nx.conv_start = 1'b1;
          nx.started    = 1'b1;
        end
      end
      ais_pkg::CV_BUSY: begin
        // R16 flag set wins over clear
        // R8 pending selection applied at end
        if (conv_done_i) begin
          nx.cst                = ais_pkg::CV_IDLE;
          nx.result             = 16'(result_i);
          nx.stat[`AIS_ST_DONE] = 1'b1;
          if (st.pend && !wr_mux) begin
            nx.sel_eff = st.sel_pend;
            nx.pend    = 1'b0;
          end else if (wr_mux) begin
            nx.sel_eff = new_sel;
            nx.pend    = 1'b0;
          end
        end
      end
      default: nx.cst = ais_pkg::CV_OFF;
    endcase
    // R17 disable aborts and releases pending select
    if (wr_csra && !st.wdata[`AIS_CSRA_EN]) begin
      nx.cst     = ais_pkg::CV_OFF;
      nx.started = 1'b0;
      if (st.pend) begin
        nx.sel_eff = st.sel_pend;
        nx.pend    = 1'b0;
      end
    end
    nx.en = nx.cst != ais_pkg::CV_OFF;

    // R1 reference choice
    // R2 frozen once started
    if (!nx.started) begin
      nx.ref_eff = ais_pkg::ais_ref_t'(nx.mux[7:6]);
    end
    nx.gain = gain_of(nx.sel_eff);
    nx.src  = src_of(nx.sel_eff);

    // R14 clears once reset phase can be entered
    // R13 forces reset pulse; new request wins
    if (st.analog_channel_change && st.s_rst[1]) begin
      nx.analog_channel_change              = 1'b0;
      nx.ana_rst           = 1'b1;
      nx.stat[`AIS_ST_CHG] = 1'b1;
    end
    if (wr_csrb && st.wdata[`AIS_CSRB_ANALOG_CHANNEL_CHANGE]) begin
      nx.analog_channel_change = 1'b1;
    end
    nx.irq = |(nx.stat & nx.mask);
  end

  // R18 all state cleared on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready  = st.awready;
  assign s_axi_wready   = st.wready;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_arready  = st.arready;
  assign s_axi_rdata    = st.rdata;
  assign s_axi_rresp    = st.rresp;
  assign s_axi_rvalid   = st.rvalid;
  assign conv_start_o   = st.conv_start;
  assign conv_enable_o  = st.en;
  assign avdd_req_o     = st.en;
  assign ref_en_o       = st.en;
  assign ref_sel_o      = st.ref_eff;
  assign chan_sel_o     = st.sel_eff;
  assign gain_o         = st.gain;
  assign src_o          = st.src;
  assign analog_reset_o = st.ana_rst;
  assign irq_o          = st.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ref_frozen;
    st.started && $past(st.started) |-> ref_sel_o == $past(ref_sel_o);
  endproperty
  a_ref_frozen: assert property (p_ref_frozen) else $error("ref changed"); // R2

  property p_busy_hold;
    st.cst == ais_pkg::CV_BUSY ##1 st.cst == ais_pkg::CV_BUSY |-> $stable(chan_sel_o);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("sel moved busy"); // R6

  property p_high_buffered;
    wr_csrb && !st.pend |=> $stable(chan_sel_o[5]);
  endproperty
  a_high_buffered: assert property (p_high_buffered) else $error("high leaked"); // R7

  property p_mux_apply;
    wr_mux && st.cst != ais_pkg::CV_BUSY |=> chan_sel_o == $past(new_sel);
  endproperty
  a_mux_apply: assert property (p_mux_apply) else $error("sel not applied"); // R7

  property p_end_apply;
    st.cst == ais_pkg::CV_BUSY && st.pend && conv_done_i && !wr_mux && !wr_csra
      |=> chan_sel_o == $past(st.sel_pend) && !st.pend;
  endproperty
  a_end_apply: assert property (p_end_apply) else $error("pend lost"); // R8

  property p_analog_channel_change_clear;
    st.analog_channel_change && st.s_rst[1] && !wr_csrb |=> !st.analog_channel_change && analog_reset_o ##1 !analog_reset_o;
  endproperty
  a_analog_channel_change_clear: assert property (p_analog_channel_change_clear) else $error("analog_channel_change stuck"); // R14

  property p_start;
    wr_csra && st.wdata[`AIS_CSRA_START] && st.wdata[`AIS_CSRA_EN]
      && st.cst != ais_pkg::CV_BUSY |=> conv_start_o && st.cst == ais_pkg::CV_BUSY;
  endproperty
  a_start: assert property (p_start) else $error("no start"); // R15

  property p_done_set;
    st.cst == ais_pkg::CV_BUSY && conv_done_i && !(wr_csra && !st.wdata[`AIS_CSRA_EN])
      |=> st.stat[`AIS_ST_DONE] && st.cst == ais_pkg::CV_IDLE;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done missed"); // R16

  property p_disable;
    wr_csra && !st.wdata[`AIS_CSRA_EN] |=> !conv_enable_o && !ref_en_o ##1 !conv_start_o;
  endproperty
  a_disable: assert property (p_disable) else $error("not off"); // R17

  property p_write_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("no bvalid"); // R18

  c_convert: cover property (conv_start_o ##[1:200] st.stat[`AIS_ST_DONE]);
  c_deferred: cover property (wr_mux && st.cst == ais_pkg::CV_BUSY ##[1:200] !st.pend);
  c_chg_reset: cover property (wr_csrb && st.wdata[`AIS_CSRB_ANALOG_CHANNEL_CHANGE] ##[1:20] analog_reset_o);
  c_irq: cover property (!irq_o ##1 irq_o);
endmodule

/* tb_adc_input_and_reference_select.sv */
/*
  Self-checking bench of the converter control block: register sequences
  over AXI4-Lite with expected values. Assumes header and package compiled.
*/
`timescale 1ns/1ps
`include "ais_defines.svh"
module tb_adc_input_and_reference_select;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic [11:0]        s_axi_awaddr = 12'h000;
  logic [11:0]        s_axi_araddr = 12'h000;
  logic [31:0]        s_axi_wdata = 32'h00000000;
  logic [3:0]         s_axi_wstrb = 4'h1;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready = 1'b0;
  logic               conv_done_i = 1'b0;
  logic [9:0]         result_i = 10'h000;
  logic               avdd_ok_i = 1'b0;
  logic               ref_ok_i = 1'b0;
  logic               rst_phase_ok_i = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [31:0]        s_axi_rdata;
  logic               conv_start_o, conv_enable_o, avdd_req_o, ref_en_o, analog_reset_o, irq_o;
  ais_pkg::ais_ref_t  ref_sel_o;
  ais_pkg::ais_gain_t gain_o;
  ais_pkg::ais_src_t  src_o;
  logic [5:0]         chan_sel_o;
  logic [5:0]         prev;
  int                 error_cnt = 0;
  int                 num_checks = 0;
  int                 start_cnt = 0;
  int                 arst_cnt = 0;
  int                 s0;
  // Code, gain and class per entry: {code[5:0], gain[1:0], src[2:0]}
  logic [10:0]        tbl [7] = '{11'h060, 11'h111, 11'h159, 11'h209, 11'h3C2, 11'h3E3,
                                  11'h424};

  ais_ctrl #(.RES_W(10)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .conv_done_i(conv_done_i), .result_i(result_i), .avdd_ok_i(avdd_ok_i),
    .ref_ok_i(ref_ok_i), .rst_phase_ok_i(rst_phase_ok_i), .conv_start_o(conv_start_o),
    .conv_enable_o(conv_enable_o), .avdd_req_o(avdd_req_o), .ref_en_o(ref_en_o),
    .ref_sel_o(ref_sel_o), .chan_sel_o(chan_sel_o), .gain_o(gain_o), .src_o(src_o),
    .analog_reset_o(analog_reset_o), .irq_o(irq_o)
  );

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // Pulse counters, so one-cycle outputs are never missed
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) start_cnt <= start_cnt + 1;
    if (analog_reset_o === 1'b1) arst_cnt <= arst_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write master; one spare edge at the end so ready is never reassigned in one step
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    @(posedge clk_i);
  endtask

  // Read master with compare of data and response
  task automatic rd(input string nm, input logic [9:0] idx, input logic [31:0] exp,
                    input logic [1:0] er = 2'h0);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(nm, exp, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    @(posedge clk_i);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  // Sequencer end pulse with a result
  task automatic conv_end(input logic [9:0] res);
    conv_done_i <= 1'b1;
    result_i <= res;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    settle();
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("MISMATCH watchdog expected finish seen timeout");
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd("mux_rst", `AIS_IDX_MUX, 32'h0);
    rd("csrb_rst", `AIS_IDX_CSRB, 32'h0);
    rd("csra_rst", `AIS_IDX_CSRA, 32'h0);
    rd("unmapped", 10'h3FF, 32'h0, 2'h2);
    wr(10'h3FF, 8'hFF, 2'h2);
    // Reference follows the field before any start
    // no external reference applied here
    for (int r = 0; r < 4; r++) begin
      wr(`AIS_IDX_MUX, {2'(r), 6'h05});
      settle();
      chk("ref_sel", 32'(r), 32'(ref_sel_o));
      chk("chan_se", 32'h05, 32'(chan_sel_o));
    end
    // High bit buffered, then pushed by the low write
    for (int i = 0; i < 7; i++) begin
      prev = chan_sel_o;
      wr(`AIS_IDX_CSRB, {4'h0, tbl[i][10], 3'h0});
      settle();
      chk("chan_hold", 32'(prev), 32'(chan_sel_o));
      wr(`AIS_IDX_MUX, {3'h0, tbl[i][9:5]});
      settle();
      chk("chan", 32'(tbl[i][10:5]), 32'(chan_sel_o));
      chk("gain", 32'(tbl[i][4:3]), 32'(gain_o));
      chk("src", 32'(tbl[i][2:0]), 32'(src_o));
    end
    wr(`AIS_IDX_CSRB, 8'h00);
    wr(`AIS_IDX_MUX, 8'hC1);
    wr(`AIS_IDX_MASK, 8'h01);
    wr(`AIS_IDX_CSRA, 8'h80);
    settle();
    chk("enables", 32'h7, 32'({conv_enable_o, avdd_req_o, ref_en_o}));
    avdd_ok_i <= 1'b1;
    ref_ok_i <= 1'b1;
    settle();
    wr(`AIS_IDX_CSRB, 8'h00);
    rd("csrb_ok", `AIS_IDX_CSRB, 32'hA0);
    // Conversion with channel and reference writes while busy
    s0 = start_cnt;
    wr(`AIS_IDX_CSRA, 8'hC0);
    settle();
    chk("start_pulse", 32'(s0 + 1), 32'(start_cnt));
    rd("csra_busy", `AIS_IDX_CSRA, 32'hC0);
    wr(`AIS_IDX_CSRB, 8'h08);
    wr(`AIS_IDX_MUX, 8'h87);
    settle();
    chk("chan_busy", 32'h01, 32'(chan_sel_o));
    chk("ref_frozen", 32'h3, 32'(ref_sel_o));
    conv_end(10'h2B5);
    chk("chan_end", 32'h27, 32'(chan_sel_o));
    chk("ref_still", 32'h3, 32'(ref_sel_o));
    rd("csra_done", `AIS_IDX_CSRA, 32'h90);
    rd("data_right", `AIS_IDX_DATA, 32'h2B5);
    chk("irq_set", 32'h1, 32'(irq_o));
    wr(`AIS_IDX_MASK, 8'h00);
    settle();
    chk("irq_mask", 32'h0, 32'(irq_o));
    wr(`AIS_IDX_MASK, 8'h01);
    settle();
    chk("irq_unmask", 32'h1, 32'(irq_o));
    // Control bit 4 clears the same done flag, so it goes after the mask checks
    wr(`AIS_IDX_CSRA, 8'h90);
    rd("csra_w1c", `AIS_IDX_CSRA, 32'h80);
    chk("irq_ctl_clr", 32'h0, 32'(irq_o));
    wr(`AIS_IDX_STAT, 8'h01);
    settle();
    chk("irq_clr", 32'h0, 32'(irq_o));
    // Alignment flips at once during a second conversion
    wr(`AIS_IDX_CSRA, 8'hC0);
    wr(`AIS_IDX_MUX, 8'hA7);
    rd("data_left", `AIS_IDX_DATA, 32'hAD40);
    wr(`AIS_IDX_CSRA, 8'h00);
    settle();
    rd("csra_off", `AIS_IDX_CSRA, 32'h00);
    chk("enable_off", 32'h0, 32'(conv_enable_o));
    chk("ref_unlock", 32'h2, 32'(ref_sel_o));
    // Forced analog reset waits for the reset phase
    avdd_ok_i <= 1'b0;
    ref_ok_i <= 1'b0;
    wr(`AIS_IDX_MASK, 8'h02);
    // Status bits ignore writes; a write without byte enable changes nothing
    wr(`AIS_IDX_CSRB, 8'hE7);
    rd("csrb_ro", `AIS_IDX_CSRB, 32'h47);
    s_axi_wstrb <= 4'h0;
    wr(`AIS_IDX_CSRB, 8'h00);
    s_axi_wstrb <= 4'h1;
    rd("csrb_nostrb", `AIS_IDX_CSRB, 32'h47);
    s0 = arst_cnt;
    wr(`AIS_IDX_CSRB, 8'h18);
    settle();
    rd("analog_channel_change_pend", `AIS_IDX_CSRB, 32'h18);
    chk("no_reset", 32'(s0), 32'(arst_cnt));
    rst_phase_ok_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("reset_pulse", 32'(s0 + 1), 32'(arst_cnt));
    rd("analog_channel_change_clr", `AIS_IDX_CSRB, 32'h08);
    chk("irq_chg", 32'h1, 32'(irq_o));
    wr(`AIS_IDX_STAT, 8'h02);
    settle();
    chk("irq_chg_clr", 32'h0, 32'(irq_o));
    print_verdict();
  end
endmodule
